/* verilog/sld_pkg.sv */
// Package with register map, field positions and timing of the supply level detector
package sld_pkg;
  // Wishbone word addresses (byte offsets)
  localparam logic [3:0] SLD_ADDR_CTRL = 4'h0;
  localparam logic [3:0] SLD_ADDR_STAT = 4'h4;
  localparam logic [3:0] SLD_ADDR_IRQ_STAT = 4'h8;
  localparam logic [3:0] SLD_ADDR_IRQ_MASK = 4'hc;
  // Control register fields
  localparam int SLD_CTRL_RANGE_BIT = 3;
  localparam int SLD_CTRL_TRIM_MSB = 2;
  // Status register fields
  localparam int SLD_STAT_RESULT_BIT = 2;
  localparam int SLD_STAT_VALID_BIT = 1;
  localparam int SLD_STAT_ENABLE_BIT = 0;
  // Interrupt status bits
  localparam int SLD_IRQ_LOW_BIT = 0;
  localparam int SLD_IRQ_VALID_BIT = 1;
  localparam int SLD_IRQ_WIDTH = 2;
  // Position in the mid priority interrupt bank
  localparam int SLD_MID_BANK_BIT = 2;
  localparam int SLD_MID_BANK_WIDTH = 8;
  // Reset values
  localparam logic [7:0] SLD_CTRL_RESET = 8'h00;
  localparam logic [7:0] SLD_STAT_RESET = 8'h00;
  localparam logic [1:0] SLD_IRQ_RESET = 2'h0;
  // Timing
  localparam int SLD_CLK_HZ = 50000000;
  localparam int SLD_SETTLE_US = 2000;
  localparam int SLD_SETTLE_CYCLES = (SLD_CLK_HZ / 1000000) * SLD_SETTLE_US;
  // Enable state sequence
  typedef enum logic [1:0] {
    SLD_OFF,
    SLD_SETTLE,
    SLD_VALID
  } sld_state_t;
endpackage

/* verilog/sld_ctrl.sv */
// Supply level detector control, status, Wishbone slave and interrupt logic
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
module sld_ctrl #(
  parameter int SETTLE_CYCLES = sld_pkg::SLD_SETTLE_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Analog comparator
  input wire logic comp_below,
  output logic detector_enable,
  output logic range_select,
  output logic [2:0] level_trim,
  // Interrupts
  output logic low_supply_irq,
  output logic [sld_pkg::SLD_MID_BANK_WIDTH-1:0] mid_priority_irq_bank
);
  import sld_pkg::*;

  localparam int CW = $clog2(SETTLE_CYCLES + 1);
  localparam logic [CW-1:0] SETTLE_LAST = CW'(SETTLE_CYCLES - 1);

  logic [7:0] ctrl_reg;
  logic enable_reg;
  logic valid_reg;
  logic result_reg;
  logic result_prev_reg;
  logic [2:0] below_sync_reg;
  logic [CW-1:0] settle_cnt_reg;
  sld_state_t state_reg;
  logic [SLD_IRQ_WIDTH-1:0] irq_stat_reg;
  logic [SLD_IRQ_WIDTH-1:0] irq_mask_reg;
  logic [SLD_IRQ_WIDTH-1:0] irq_event;
  logic wb_req;
  logic wr_lane0;
  logic low_edge;

  //////////////////////////////////////////////////////////////////////////////
  // Wishbone access: one ack cycle after the request, dropped the next cycle
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_lane0 = wb_req && wb_we_i && wb_sel_i[0];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      if (wb_adr_i == SLD_ADDR_CTRL) begin
        wb_dat_o <= {24'h00_0000, ctrl_reg};
      end else if (wb_adr_i == SLD_ADDR_STAT) begin
        wb_dat_o <= {29'h0000_0000, result_reg, valid_reg, enable_reg};
      end else if (wb_adr_i == SLD_ADDR_IRQ_STAT) begin
        wb_dat_o <= {30'h0000_0000, irq_stat_reg};
      end else if (wb_adr_i == SLD_ADDR_IRQ_MASK) begin
        wb_dat_o <= {30'h0000_0000, irq_mask_reg};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control and enable registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= SLD_CTRL_RESET;
    end else if (wr_lane0 && wb_adr_i == SLD_ADDR_CTRL) begin
      ctrl_reg <= {4'h0, wb_dat_i[3:0]};
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      enable_reg <= 1'b0;
    end else if (wr_lane0 && wb_adr_i == SLD_ADDR_STAT) begin
      enable_reg <= wb_dat_i[SLD_STAT_ENABLE_BIT];
    end
  end

  // Analog controls held in flops so the pins never glitch
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      detector_enable <= 1'b0;
      range_select <= 1'b0;
      level_trim <= 3'h0;
    end else begin
      detector_enable <= enable_reg;
      range_select <= ctrl_reg[SLD_CTRL_RANGE_BIT];
      level_trim <= ctrl_reg[SLD_CTRL_TRIM_MSB:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Settling sequence; clearing enable aborts it at once
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= SLD_OFF;
      settle_cnt_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      case (state_reg)
        SLD_OFF: begin
          valid_reg <= 1'b0;
          settle_cnt_reg <= '0;
          if (enable_reg) begin
            state_reg <= SLD_SETTLE;
          end
        end
        SLD_SETTLE: begin
          if (!enable_reg) begin
            state_reg <= SLD_OFF;
          end else if (settle_cnt_reg == SETTLE_LAST) begin
            state_reg <= SLD_VALID;
            valid_reg <= 1'b1;
          end else begin
            settle_cnt_reg <= settle_cnt_reg + 1'b1;
          end
        end
        SLD_VALID: begin
          if (!enable_reg) begin
            state_reg <= SLD_OFF;
            valid_reg <= 1'b0;
          end
        end
        default: begin
          state_reg <= SLD_OFF;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Comparator result: three-stage synchroniser, change accepted when stages 2 and 3 agree
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      below_sync_reg <= 3'h0;
    end else begin
      below_sync_reg <= {below_sync_reg[1:0], comp_below};
    end
  end

  // Result is forced low while off, since the comparator output is meaningless then
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      result_reg <= 1'b0;
      result_prev_reg <= 1'b0;
    end else begin
      if (!detector_enable) begin
        result_reg <= 1'b0;
      end else if (below_sync_reg[1] == below_sync_reg[2]) begin
        result_reg <= below_sync_reg[2];
      end
      result_prev_reg <= result_reg;
    end
  end

  assign low_edge = result_reg && !result_prev_reg && valid_reg && enable_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Sticky interrupt status, write one to clear; a new event wins over the clear
  always_comb begin
    irq_event = '0;
    irq_event[SLD_IRQ_LOW_BIT] = low_edge;
    irq_event[SLD_IRQ_VALID_BIT] = (state_reg == SLD_SETTLE) && enable_reg &&
                                   (settle_cnt_reg == SETTLE_LAST);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_reg <= SLD_IRQ_RESET;
    end else begin
      for (int i = 0; i < SLD_IRQ_WIDTH; i++) begin
        if (irq_event[i]) begin
          irq_stat_reg[i] <= 1'b1;
        end else if (wr_lane0 && wb_adr_i == SLD_ADDR_IRQ_STAT && wb_dat_i[i]) begin
          irq_stat_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_mask_reg <= SLD_IRQ_RESET;
    end else if (wr_lane0 && wb_adr_i == SLD_ADDR_IRQ_MASK) begin
      irq_mask_reg <= wb_dat_i[SLD_IRQ_WIDTH-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_supply_irq <= 1'b0;
      mid_priority_irq_bank <= '0;
    end else begin
      low_supply_irq <= |(irq_stat_reg & irq_mask_reg);
      mid_priority_irq_bank <= '0;
      mid_priority_irq_bank[SLD_MID_BANK_BIT] <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_valid_after_settle;
    @(posedge core_clk) disable iff (!arst_n)
      (state_reg == SLD_SETTLE && enable_reg && settle_cnt_reg == SETTLE_LAST) |=> valid_reg;
  endproperty
  a_valid_after_settle: assert property (p_valid_after_settle)
    else $error("valid flag not set at end of settling");

  property p_no_early_valid;
    @(posedge core_clk) disable iff (!arst_n)
      $rose(enable_reg) |-> !valid_reg [*3];
  endproperty
  a_no_early_valid: assert property (p_no_early_valid)
    else $error("valid flag set too early");

  property p_edge_sets_irq;
    @(posedge core_clk) disable iff (!arst_n)
      ($rose(result_reg) && valid_reg && enable_reg) |=> irq_stat_reg[SLD_IRQ_LOW_BIT];
  endproperty
  a_edge_sets_irq: assert property (p_edge_sets_irq)
    else $error("rising result did not set interrupt status");

  property p_no_irq_on_fall;
    @(posedge core_clk) disable iff (!arst_n)
      $rose(irq_stat_reg[SLD_IRQ_LOW_BIT]) |-> $past(result_reg) && !$past(result_prev_reg);
  endproperty
  a_no_irq_on_fall: assert property (p_no_irq_on_fall)
    else $error("interrupt event without rising result");

  property p_no_irq_invalid;
    @(posedge core_clk) disable iff (!arst_n)
      !valid_reg |=> !$rose(irq_stat_reg[SLD_IRQ_LOW_BIT]);
  endproperty
  a_no_irq_invalid: assert property (p_no_irq_invalid)
    else $error("interrupt event before valid");

  property p_enable_pin;
    @(posedge core_clk) disable iff (!arst_n)
      $changed(enable_reg) |=> detector_enable == $past(enable_reg);
  endproperty
  a_enable_pin: assert property (p_enable_pin)
    else $error("detector enable pin does not follow register");

  property p_valid_needs_enable;
    @(posedge core_clk) disable iff (!arst_n)
      $fell(enable_reg) |=> !valid_reg;
  endproperty
  a_valid_needs_enable: assert property (p_valid_needs_enable)
    else $error("valid flag survives disable");

  property p_reserved_zero;
    @(posedge core_clk) disable iff (!arst_n)
      ctrl_reg[7:4] == 4'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved control bits not zero");

  property p_trim_pin;
    @(posedge core_clk) disable iff (!arst_n)
      $changed(ctrl_reg) |=> level_trim == $past(ctrl_reg[2:0]) &&
                             range_select == $past(ctrl_reg[3]);
  endproperty
  a_trim_pin: assert property (p_trim_pin)
    else $error("trim or range pin does not follow register");

  property p_bank_irq;
    @(posedge core_clk) disable iff (!arst_n)
      mid_priority_irq_bank[SLD_MID_BANK_BIT] ==
        $past((irq_stat_reg[SLD_IRQ_LOW_BIT] && irq_mask_reg[SLD_IRQ_LOW_BIT]) ||
              (irq_stat_reg[SLD_IRQ_VALID_BIT] && irq_mask_reg[SLD_IRQ_VALID_BIT]));
  endproperty
  a_bank_irq: assert property (p_bank_irq)
    else $error("bank bit differs from interrupt");

  property p_ack_one_cycle;
    @(posedge core_clk) disable iff (!arst_n)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one_cycle: assert property (p_ack_one_cycle)
    else $error("ack held longer than one cycle");

  property p_reset_clear;
    @(posedge core_clk) disable iff (!arst_n)
      $rose(arst_n) |-> ctrl_reg == SLD_CTRL_RESET && !enable_reg && !valid_reg &&
                        !result_reg && irq_stat_reg == SLD_IRQ_RESET &&
                        irq_mask_reg == SLD_IRQ_RESET && state_reg == SLD_OFF;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("state not cleared by reset");

  property p_result_off;
    @(posedge core_clk) disable iff (!arst_n)
      !detector_enable |=> !result_reg;
  endproperty
  a_result_off: assert property (p_result_off)
    else $error("result flag set while detector is off");

  property p_enable_write;
    @(posedge core_clk) disable iff (!arst_n)
      (wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o &&
       wb_adr_i == SLD_ADDR_STAT) |=> enable_reg == $past(wb_dat_i[SLD_STAT_ENABLE_BIT]);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable bit not written");

  property p_valid_off;
    @(posedge core_clk) disable iff (!arst_n)
      !enable_reg |=> !valid_reg;
  endproperty
  a_valid_off: assert property (p_valid_off)
    else $error("valid flag set while disabled");

  property p_irq_level;
    @(posedge core_clk) disable iff (!arst_n)
      (irq_stat_reg[SLD_IRQ_LOW_BIT] && irq_mask_reg[SLD_IRQ_LOW_BIT]) |=> low_supply_irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("unmasked low supply status without interrupt");

  // Guards against a metastable first stage leaking into the result
  property p_sync_stable;
    @(posedge core_clk) disable iff (!arst_n)
      (detector_enable && below_sync_reg[1] != below_sync_reg[2]) |=> $stable(result_reg);
  endproperty
  a_sync_stable: assert property (p_sync_stable)
    else $error("result changed before synchroniser stages agreed");
endmodule

/* sim/sld_tb.sv */
// Self-checking testbench of the supply level detector control block
`timescale 1ns/1ps
module testbench;
  import sld_pkg::*;
  localparam int SETTLE = 20;
  logic core_clk;
  logic arst_n;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic comp_below;
  logic [3:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic wb_ack_o;
  logic detector_enable;
  logic range_select;
  logic low_supply_irq;
  logic [2:0] level_trim;
  logic [SLD_MID_BANK_WIDTH-1:0] mid_priority_irq_bank;
  logic [7:0] cv;
  int error_cnt;
  int cmp_count;
  int seed;

  sld_ctrl #(.SETTLE_CYCLES(SETTLE)) u_sld_ctrl (
    .core_clk(core_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .comp_below(comp_below),
    .detector_enable(detector_enable), .range_select(range_select),
    .level_trim(level_trim), .low_supply_irq(low_supply_irq),
    .mid_priority_irq_bank(mid_priority_irq_bank)
  );

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] exp_ctrl(input logic [7:0] v);
    return {28'h0, v[3:0]};
  endfunction

  task automatic stop_test();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Ack is sampled at the rising edge; read data is taken and the request released there
  task automatic wb_cycle(input logic we, input logic [3:0] adr, input logic [31:0] dat,
                          input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do begin
      @(posedge core_clk);
      n++;
      if (n > 20) begin
        error_cnt++;
        stop_test();
      end
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] adr, input logic [31:0] dat);
    wb_cycle(1'b1, adr, dat, 4'hf);
  endtask

  task automatic rdchk(input logic [3:0] adr, input logic [31:0] exp);
    wb_cycle(1'b0, adr, 32'h0, 4'hf);
    chk(rd, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic set_comp(input logic v);
    @(posedge core_clk);
    comp_below <= v;
  endtask

  task automatic chk_irq(input logic v);
    @(negedge core_clk);
    chk({low_supply_irq, mid_priority_irq_bank}, {v, 8'(v) << SLD_MID_BANK_BIT});
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    comp_below = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    seed = $urandom(2);
    idle(2);
    arst_n <= 1'b1;
    @(negedge core_clk);
    chk({detector_enable, range_select, level_trim, low_supply_irq}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rdchk(4'(i * 4), 32'h0);
    end
    $display("Test reset values done");
    for (int i = 0; i < 8; i++) begin
      cv = {4'($urandom), 1'($urandom), 3'(i)};
      wr(SLD_ADDR_CTRL, {24'($urandom), cv});
      rdchk(SLD_ADDR_CTRL, exp_ctrl(cv));
      @(negedge core_clk);
      chk({range_select, level_trim}, exp_ctrl(cv));
    end
    wr(4'h2, 32'hff);
    rdchk(4'h2, 32'h0);
    // A write with byte lane 0 off must leave the control register alone
    wb_cycle(1'b1, SLD_ADDR_CTRL, 32'h0, 4'he);
    rdchk(SLD_ADDR_CTRL, exp_ctrl(cv));
    $display("Test control register done");
    // Comparator noise while off must leave no trace
    repeat (10) set_comp(1'($urandom));
    set_comp(1'b1);
    idle(6);
    rdchk(SLD_ADDR_STAT, 32'h0);
    rdchk(SLD_ADDR_IRQ_STAT, 32'h0);
    set_comp(1'b0);
    wr(SLD_ADDR_IRQ_MASK, 32'h3);
    wr(SLD_ADDR_STAT, 32'hff);
    idle(1);
    @(negedge core_clk);
    chk(detector_enable, 1'b1);
    rdchk(SLD_ADDR_STAT, 32'h1);
    idle(12);
    rdchk(SLD_ADDR_STAT, 32'h1);
    idle(2);
    rdchk(SLD_ADDR_STAT, 32'h3);
    rdchk(SLD_ADDR_IRQ_STAT, 32'h2);
    chk_irq(1'b1);
    wr(SLD_ADDR_IRQ_STAT, 32'h2);
    idle(2);
    chk_irq(1'b0);
    $display("Test enable and settling done");
    for (int k = 0; k < 4; k++) begin
      set_comp(1'b1);
      idle(10 + ($urandom % 6));
      chk_irq(1'b1);
      rdchk(SLD_ADDR_STAT, 32'h7);
      rdchk(SLD_ADDR_IRQ_STAT, 32'h1);
      wr(SLD_ADDR_IRQ_STAT, 32'h1);
      idle(8);
      rdchk(SLD_ADDR_IRQ_STAT, 32'h0);
      chk_irq(1'b0);
      set_comp(1'b0);
      idle(8 + ($urandom % 6));
      rdchk(SLD_ADDR_IRQ_STAT, 32'h0);
      rdchk(SLD_ADDR_STAT, 32'h3);
    end
    wr(SLD_ADDR_IRQ_MASK, 32'h0);
    set_comp(1'b1);
    idle(12);
    chk_irq(1'b0);
    rdchk(SLD_ADDR_IRQ_STAT, 32'h1);
    wr(SLD_ADDR_IRQ_MASK, 32'h1);
    idle(2);
    chk_irq(1'b1);
    wr(SLD_ADDR_IRQ_STAT, 32'h1);
    idle(2);
    chk_irq(1'b0);
    $display("Test low supply interrupt done");
    wr(SLD_ADDR_STAT, 32'h0);
    idle(2);
    @(negedge core_clk);
    chk(detector_enable, 1'b0);
    rdchk(SLD_ADDR_STAT, 32'h0);
    arst_n <= 1'b0;
    @(negedge core_clk);
    chk({detector_enable, range_select, level_trim, low_supply_irq}, 32'h0);
    @(posedge core_clk);
    arst_n <= 1'b1;
    rdchk(SLD_ADDR_CTRL, 32'h0);
    rdchk(SLD_ADDR_IRQ_MASK, 32'h0);
    $display("Test disable and reset done");
    stop_test();
  end
endmodule
